//--- pkg/odcc_pkg.sv
package odcc_pkg;
  // command opcodes
  localparam logic [7:0] CMD_MUX = 8'hA8;
  localparam logic [7:0] CMD_PUMP = 8'hAD;
  localparam logic [7:0] CMD_PUMP_DATA = 8'h8A;
  localparam logic [7:0] CMD_DISP = 8'hAE;
  localparam logic [7:0] CMD_PAGE = 8'hB0;
  localparam logic [7:0] CMD_SCAN = 8'hC0;
  localparam logic [7:0] CMD_OFFSET = 8'hD3;
  localparam logic [7:0] CMD_CLOCK = 8'hD5;
  // opcode match masks
  localparam logic [7:0] MASK_LSB = 8'hFE;
  localparam logic [7:0] MASK_PAGE = 8'hF8;
  localparam logic [7:0] MASK_SCAN = 8'hF0;
  // field positions
  localparam int SCAN_BIT = 3;
  localparam int ONOFF_BIT = 0;
  // reset values
  localparam logic [5:0] MUX_RST = 6'h3F;
  localparam logic PUMP_RST = 1'b1;
  localparam logic DISP_RST = 1'b0;
  localparam logic [2:0] PAGE_RST = 3'h0;
  localparam logic SCAN_RST = 1'b0;
  localparam logic [5:0] OFFSET_RST = 6'h00;
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [3:0] TRIM_RST = 4'h5;
  // decoder states
  typedef enum logic [2:0] {
    ODCC_IDLE = 3'b000,
    ODCC_ARG_MUX = 3'b001,
    ODCC_ARG_PUMP = 3'b010,
    ODCC_ARG_OFFSET = 3'b011,
    ODCC_ARG_CLOCK = 3'b100
  } odcc_state_t;
endpackage : odcc_pkg

//--- pkg/odcc_if.sv
`timescale 1ns/1ps
interface odcc_if;
  logic wr_stb;
  logic cmd_data_select;
  logic [7:0] wr_data;
  modport host (output wr_stb, output cmd_data_select, output wr_data);
  modport dev (input wr_stb, input cmd_data_select, input wr_data);
endinterface : odcc_if

//--- design/odcc_tick_div.sv
`timescale 1ns/1ps
module odcc_tick_div #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic [W-1:0] ratio_m1,
  // tick out
  output logic tick
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_tick;

  // counts ratio_m1+1 cycles per tick; count cleared to zero while stopped
  always_comb
  begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (run)
    begin
      if (cnt >= ratio_m1)
      begin
        next_cnt = '0;
        next_tick = 1'b1;
      end
      else
        next_cnt = cnt + 1'b1;
    end
    else
      next_cnt = '0;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : odcc_tick_div

//--- design/odcc_device.sv
// Operation
// - A8H then ratio byte, low six bits
// - ADH then 8AH/8BH sets converter enable
// - host changes converter only while display off
// - display off means sleep, regardless of converter
// - converter off, display on: external supply
// - AEH/AFH switches panel off or on
// - display off halts oscillator and converter
// - sleep floats segment and common outputs
// - sleep keeps all settings intact
// - host RAM access still allowed in sleep
// - B0H-B7H loads page address register
// - page change leaves panel picture unchanged
// - C0H/C8H sets common scan direction
// - scan direction takes effect immediately
// - D3H then six-bit display offset
// - offset k shifts up; 64-k shifts down
// - D5H data low nibble sets divide ratio
// - D5H data high nibble trims oscillator
// - frame rate follows clock, divider and mux
// - host sends only defined command codes
`timescale 1ns/1ps
module odcc_device (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // host port
  odcc_if.dev bus,
  // panel configuration
  output logic [5:0] mux_ratio_m1,
  output logic pump_enable,
  output logic display_on,
  output logic [2:0] page_addr,
  output logic scan_reverse,
  output logic [5:0] display_offset,
  output logic [3:0] clock_div_m1,
  output logic [3:0] osc_trim,
  // power and drive status
  output logic sleep_mode,
  output logic pump_running,
  output logic osc_running,
  output logic drive_oe_b,
  output logic ram_access_en,
  output logic display_clock_tick
);
  odcc_pkg::odcc_state_t state;
  odcc_pkg::odcc_state_t next_state;
  logic [5:0] next_mux;
  logic next_pump;
  logic next_disp;
  logic [2:0] next_page;
  logic next_scan;
  logic [5:0] next_offset;
  logic [3:0] next_div;
  logic [3:0] next_trim;
  logic cmd_stb;
  logic [7:0] d;
  logic tick;

  assign cmd_stb = bus.wr_stb && !bus.cmd_data_select;
  assign d = bus.wr_data;

  ////////////////////////////////////////////////////////////////////
  // command decoder; unknown single bytes are ignored, the host must
  // not send them, so no error path is kept
  always_comb
  begin
    next_state = state;
    next_mux = mux_ratio_m1;
    next_pump = pump_enable;
    next_disp = display_on;
    next_page = page_addr;
    next_scan = scan_reverse;
    next_offset = display_offset;
    next_div = clock_div_m1;
    next_trim = osc_trim;
    if (cmd_stb)
    begin
      case (state)
        odcc_pkg::ODCC_ARG_MUX:
        begin
          next_mux = d[5:0];
          next_state = odcc_pkg::ODCC_IDLE;
        end
        odcc_pkg::ODCC_ARG_PUMP:
        begin
          // only 8AH/8BH carry a setting; anything else is dropped
          if ((d & odcc_pkg::MASK_LSB) == odcc_pkg::CMD_PUMP_DATA)
            next_pump = d[odcc_pkg::ONOFF_BIT];
          next_state = odcc_pkg::ODCC_IDLE;
        end
        odcc_pkg::ODCC_ARG_OFFSET:
        begin
          next_offset = d[5:0];
          next_state = odcc_pkg::ODCC_IDLE;
        end
        odcc_pkg::ODCC_ARG_CLOCK:
        begin
          next_div = d[3:0];
          next_trim = d[7:4];
          next_state = odcc_pkg::ODCC_IDLE;
        end
        odcc_pkg::ODCC_IDLE:
        begin
          if (d == odcc_pkg::CMD_MUX)
            next_state = odcc_pkg::ODCC_ARG_MUX;
          else if (d == odcc_pkg::CMD_PUMP)
            next_state = odcc_pkg::ODCC_ARG_PUMP;
          else if (d == odcc_pkg::CMD_OFFSET)
            next_state = odcc_pkg::ODCC_ARG_OFFSET;
          else if (d == odcc_pkg::CMD_CLOCK)
            next_state = odcc_pkg::ODCC_ARG_CLOCK;
          else if ((d & odcc_pkg::MASK_LSB) == odcc_pkg::CMD_DISP)
            next_disp = d[odcc_pkg::ONOFF_BIT];
          else if ((d & odcc_pkg::MASK_PAGE) == odcc_pkg::CMD_PAGE)
            next_page = d[2:0];
          else if ((d & odcc_pkg::MASK_SCAN) == odcc_pkg::CMD_SCAN)
            next_scan = d[odcc_pkg::SCAN_BIT];
        end
        default:
          next_state = odcc_pkg::ODCC_IDLE;
      endcase
    end
  end

  // settings registers; sleep never touches them, so waking restores all
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= odcc_pkg::ODCC_IDLE;
      mux_ratio_m1 <= odcc_pkg::MUX_RST;
      pump_enable <= odcc_pkg::PUMP_RST;
      display_on <= odcc_pkg::DISP_RST;
      page_addr <= odcc_pkg::PAGE_RST;
      scan_reverse <= odcc_pkg::SCAN_RST;
      display_offset <= odcc_pkg::OFFSET_RST;
      clock_div_m1 <= odcc_pkg::DIV_RST;
      osc_trim <= odcc_pkg::TRIM_RST;
    end
    else
    begin
      state <= next_state;
      mux_ratio_m1 <= next_mux;
      pump_enable <= next_pump;
      display_on <= next_disp;
      page_addr <= next_page;
      scan_reverse <= next_scan;
      display_offset <= next_offset;
      clock_div_m1 <= next_div;
      osc_trim <= next_trim;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // power state is taken from the next settings, so it moves in the same
  // cycle as the display switch and never shows a stale awake state
  logic next_sleep;
  logic next_pump_run;
  logic next_osc_run;
  logic next_oe_b;

  always_comb
  begin
    next_sleep = !next_disp;
    next_osc_run = next_disp;
    next_pump_run = next_disp && next_pump;
    next_oe_b = !next_disp;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sleep_mode <= 1'b1;
      osc_running <= 1'b0;
      pump_running <= 1'b0;
      drive_oe_b <= 1'b1;
      ram_access_en <= 1'b0;
      display_clock_tick <= 1'b0;
    end
    else
    begin
      sleep_mode <= next_sleep;
      osc_running <= next_osc_run;
      pump_running <= next_pump_run;
      drive_oe_b <= next_oe_b;
      ram_access_en <= 1'b1;
      display_clock_tick <= tick;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // display clock; ref_clk stands in for the oscillator, trim is only
  // reported since frequency scaling is analog
  odcc_tick_div #(
    .W(4)
  ) odcc_tick_div_inst (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .run(osc_running),
    .ratio_m1(clock_div_m1),
    .tick(tick)
  );
endmodule : odcc_device

//--- design/odcc_host.sv
`timescale 1ns/1ps
module odcc_host (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // user request
  input wire logic req_valid,
  input wire logic [7:0] req_opcode,
  input wire logic req_two_byte,
  input wire logic [7:0] req_arg,
  output logic req_ready,
  // host port
  odcc_if.host bus
);
  logic busy;
  logic second;
  logic [7:0] arg_q;
  logic next_busy;
  logic next_second;
  logic [7:0] next_arg;
  logic next_stb;
  logic [7:0] next_data;
  logic stb_q;
  logic [7:0] data_q;
  logic next_ready;

  ////////////////////////////////////////////////////////////////////
  // sends opcode, then parameter on the next cycle; callers must only
  // request defined codes and change the converter with display off
  always_comb
  begin
    next_busy = busy;
    next_second = 1'b0;
    next_arg = arg_q;
    next_stb = 1'b0;
    next_data = data_q;
    if (second)
    begin
      next_stb = 1'b1;
      next_data = arg_q;
      next_busy = 1'b0;
    end
    else if (!busy && req_valid)
    begin
      next_stb = 1'b1;
      next_data = req_opcode;
      next_arg = req_arg;
      next_second = req_two_byte;
      next_busy = req_two_byte;
    end
    // ready is registered so the user side sees a clean flop output
    next_ready = !next_busy;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy <= 1'b0;
      second <= 1'b0;
      arg_q <= 8'h00;
      stb_q <= 1'b0;
      data_q <= 8'h00;
      req_ready <= 1'b1;
    end
    else
    begin
      busy <= next_busy;
      second <= next_second;
      arg_q <= next_arg;
      stb_q <= next_stb;
      data_q <= next_data;
      req_ready <= next_ready;
    end
  end

  assign bus.wr_stb = stb_q;
  assign bus.wr_data = data_q;
  assign bus.cmd_data_select = 1'b0;
endmodule : odcc_host

//--- tb/odcc_chk.sv
`timescale 1ns/1ps
module odcc_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // host port
  input wire logic wr_stb,
  input wire logic cmd_data_select,
  input wire logic [7:0] wr_data,
  // device state
  input wire logic [5:0] mux_ratio_m1,
  input wire logic display_on,
  input wire logic [2:0] page_addr,
  input wire logic scan_reverse,
  input wire logic [5:0] display_offset,
  input wire logic [3:0] clock_div_m1,
  input wire logic [3:0] osc_trim,
  input wire logic sleep_mode,
  input wire logic osc_running,
  input wire logic pump_running,
  input wire logic drive_oe_b,
  input wire logic pump_enable
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  logic pend, next_pend;
  logic [7:0] last_op, next_last_op;
  wire cmd = wr_stb && !cmd_data_select;
  wire op = cmd && !pend;
  wire arg = cmd && pend;
  ////////////////////////////////////////
  // shadow of the decoder: any byte after a two-byte opcode is its parameter
  always_comb
  begin
    next_pend = pend;
    next_last_op = last_op;
    if (cmd)
      next_pend = !pend && (wr_data inside {8'hA8, 8'hAD, 8'hD3, 8'hD5});
    if (op)
      next_last_op = wr_data;
  end
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend <= 1'b0;
      last_op <= 8'h00;
    end
    else
    begin
      pend <= next_pend;
      last_op <= next_last_op;
    end
  end
  ////////////////////////////////////////
  // power state moves with the display switch in the same cycle
  sleep_track_a: assert property (
    sleep_mode == !display_on) else $error("sleep state wrong");
  halt_off_a: assert property (
    !display_on |-> !osc_running && !pump_running) else $error("clock or pump running");
  pump_run_a: assert property (
    pump_running == (display_on && pump_enable)) else $error("pump state wrong");
  pump_set_a: assert property (
    arg && last_op == 8'hAD && wr_data[7:1] == 7'h45 |=> pump_enable == $past(wr_data[0]))
    else $error("pump bad");
  drive_float_a: assert property (
    drive_oe_b == sleep_mode) else $error("drivers not floated in sleep");
  // settings load from the byte that was taken
  disp_switch_a: assert property (
    op && wr_data[7:1] == 7'h57 |=> display_on == $past(wr_data[0])) else $error("display bad");
  page_load_a: assert property (
    op && wr_data[7:3] == 5'h16 |=> page_addr == $past(wr_data[2:0])) else $error("page bad");
  scan_dir_a: assert property (
    op && wr_data[7:4] == 4'hC |=> scan_reverse == $past(wr_data[3])) else $error("scan bad");
  mux_set_a: assert property (
    arg && last_op == 8'hA8 |=> mux_ratio_m1 == $past(wr_data[5:0])) else $error("mux bad");
  offset_set_a: assert property (
    arg && last_op == 8'hD3 |=> display_offset == $past(wr_data[5:0])) else $error("offset bad");
  clock_set_a: assert property (
    arg && last_op == 8'hD5 |=> {osc_trim, clock_div_m1} == $past(wr_data)) else $error("clk bad");
endmodule : odcc_chk

//--- tb/oled_display_config_commands_tb_top.sv
`timescale 1ns/1ps
module oled_display_config_commands_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic req_two_byte = 1'b0;
  logic [7:0] req_opcode = 8'h00;
  logic [7:0] req_arg = 8'h00;
  logic req_ready, pump_enable, display_on, scan_reverse, sleep_mode, pump_running;
  logic osc_running, drive_oe_b, ram_access_en, display_clock_tick;
  logic [5:0] mux_ratio_m1, display_offset;
  logic [3:0] clock_div_m1, osc_trim;
  logic [2:0] page_addr;
  int n_mismatch = 0;
  int samples_checked = 0;
  odcc_if odcc_bus ();
  odcc_host odcc_host_inst (.ref_clk, .rst_b, .req_valid, .req_opcode, .req_two_byte,
    .req_arg, .req_ready, .bus(odcc_bus.host));
  odcc_device odcc_device_inst (.ref_clk, .rst_b, .bus(odcc_bus.dev), .mux_ratio_m1,
    .pump_enable, .display_on, .page_addr, .scan_reverse, .display_offset, .clock_div_m1,
    .osc_trim, .sleep_mode, .pump_running, .osc_running, .drive_oe_b, .ram_access_en,
    .display_clock_tick);
  odcc_chk odcc_chk_inst (.ref_clk, .rst_b, .wr_stb(odcc_bus.wr_stb),
    .cmd_data_select(odcc_bus.cmd_data_select), .wr_data(odcc_bus.wr_data), .mux_ratio_m1,
    .display_on, .page_addr, .scan_reverse, .display_offset, .clock_div_m1, .osc_trim,
    .sleep_mode, .osc_running, .pump_running, .drive_oe_b, .pump_enable);
  // free-running 10 MHz clock
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////
  // helpers
  task stop_test;
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // bounded wait so a stuck host ends the run instead of hanging it
  task wait_ready;
    for (int i = 0; i < 20 && req_ready !== 1'b1; i++)
      @(negedge ref_clk);
    if (req_ready !== 1'b1)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask : wait_ready
  // two extra cycles let the device take the last byte before the checks
  task send(input logic [7:0] op, input logic two, input logic [7:0] arg);
    wait_ready();
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_opcode <= op;
    req_two_byte <= two;
    req_arg <= arg;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    @(negedge ref_clk);
    wait_ready();
    repeat (2) @(negedge ref_clk);
  endtask : send
  task ticks(input int cyc, input logic [7:0] exp);
    int n;
    n = 0;
    repeat (cyc)
    begin
      @(negedge ref_clk);
      n += int'(display_clock_tick);
    end
    chk("ticks", n[7:0], exp);
  endtask : ticks
  ////////////////////////////////////////
  // scenarios
  task t_defaults;
    chk("mux", mux_ratio_m1, 8'h3F);
    chk("flags", {pump_enable, display_on, scan_reverse, page_addr}, 8'h20);
    chk("offset", display_offset, 8'h00);
    chk("clock", {osc_trim, clock_div_m1}, 8'h50);
    chk("power", {sleep_mode, drive_oe_b, osc_running, pump_running}, 8'h0C);
  endtask : t_defaults
  task t_config;
    send(8'hA8, 1'b1, 8'hC5);
    chk("mux", mux_ratio_m1, 8'h05);
    send(8'hA8, 1'b1, 8'hAF);
    chk("mux", {display_on, mux_ratio_m1}, 8'h2F);
    send(8'hD3, 1'b1, 8'hD0);
    chk("offset", display_offset, 8'h10);
    send(8'hD3, 1'b1, 8'h30);
    chk("offset", display_offset, 8'h30);
    send(8'hD5, 1'b1, 8'h3A);
    chk("clock", {osc_trim, clock_div_m1}, 8'h3A);
    for (int p = 0; p < 8; p++)
    begin
      send(8'hB0 | 8'(p), 1'b0, 8'h00);
      chk("page", {display_on, page_addr}, 8'(p));
    end
    // all sixteen codes, so bit three is set and the low bits are shown to be ignored
    for (int k = 0; k < 16; k++)
    begin
      send(8'hC0 | 8'(k), 1'b0, 8'h00);
      chk("scan", scan_reverse, {7'h00, k[3]});
    end
  endtask : t_config
  task t_power;
    send(8'hAD, 1'b1, 8'h8A);
    send(8'hAD, 1'b1, 8'h00);
    chk("pump", pump_enable, 8'h00);
    send(8'hAF, 1'b0, 8'h00);
    chk("power", {sleep_mode, drive_oe_b, osc_running, pump_running}, 8'h02);
    send(8'hAE, 1'b0, 8'h00);
    send(8'hAD, 1'b1, 8'h8B);
    chk("pump", pump_enable, 8'h01);
    send(8'hAF, 1'b0, 8'h00);
    chk("power", {sleep_mode, drive_oe_b, osc_running, pump_running}, 8'h03);
    ticks(110, 8'd10);
    send(8'hAE, 1'b0, 8'h00);
    chk("power", {sleep_mode, drive_oe_b, osc_running, pump_running}, 8'h0C);
    ticks(40, 8'd0);
    chk("keep", {osc_trim, clock_div_m1}, 8'h3A);
    chk("ram", ram_access_en, 8'h01);
  endtask : t_power
  ////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(negedge ref_clk);
    t_defaults();
    t_config();
    t_power();
    stop_test();
  end
endmodule : oled_display_config_commands_tb_top
